// ### hw/capacitive_touch_scan_control.sv
// Behaviour
// - Chosen slot overflow sets flag, request, stops oscillators.
// - Slot overflow halts its module's counters; chosen slot overflow halts all.
// - Start low clears counters, keeps slot timer.
// - Start rising edge switches counters on; in shared mode only module 0's slot counter runs.
// - Sense overflow sets sticky flag; software clears.
// - Reference overflow sets sticky flag; software clears.
// - Shared select: own slot or module 0.
// - Divider clocks reference counter: 1,2,4,8.
// - Sense frequency field, four steps, resets 11.
// - Reference count readable as two bytes.
// - Each module count readable as two bytes.
// - Ten-bit capacitor code per module.
// - Mux field picks one of four keys.
// - Multi-frequency enable bit per module, resets 0.
// - Hop source bit: field or hardware.
// - Hop field picks one of eight frequencies.
// - Unimplemented bits read as zero.
// - Slot time is (256 - preset) times 32.
// - Slot clock: reference oscillator or clock/4.
// - Separate reference and key oscillator enables.
// - One request per run; counters then cleared.
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "touch_scan_defines.svh"
module capacitive_touch_scan_control (
  input  wire logic                                     core_clk,
  input  wire logic                                     rst_n,
  input  wire logic                                     hsel,
  input  wire logic [31:0]                              haddr,
  input  wire logic [1:0]                               htrans,
  input  wire logic                                     hwrite,
  input  wire logic [2:0]                               hsize,
  input  wire logic [31:0]                              hwdata,
  input  wire logic                                     hready,
  input  wire logic [`TS_NUM_MOD-1:0][`TS_KEYS_PER_MOD-1:0] key_osc_in,
  input  wire logic [`TS_NUM_MOD-1:0]                   ref_osc_in,
  output logic [31:0]                                   hrdata,
  output logic                                          hreadyout,
  output logic                                          hresp,
  output logic                                          touch_irq_request,
  output logic [1:0]                                    sense_freq_select,
  output touch_scan_pkg::osc_ctrl_t [`TS_NUM_MOD-1:0]   osc_ctrl
);

  localparam int NM = `TS_NUM_MOD;

  function automatic touch_scan_pkg::addr_dec_t decode(input logic [31:0] a);
    touch_scan_pkg::addr_dec_t d;
    logic [7:0] rel;
    d = '0;
    rel = a[7:0] - `TS_MOD_BASE;
    if (a[31:8] == 24'h0 && a[1:0] == 2'h0) begin
      if (a[7:0] < `TS_MOD_BASE) begin
        d.hit = (a[7:0] <= {3'h0, `TS_OFS_REF_HI});
        d.ofs = a[4:0];
      end else begin
        d.mod    = rel[7:5];
        d.ofs    = rel[4:0];
        d.is_mod = 1'b1;
        d.hit    = (rel[7:5] < 3'(NM)) && (rel[4:0] <= `TS_OFS_MOD_CTRL);
      end
    end
    return d;
  endfunction

  // Bus state. Zero wait states; hrdata is fetched at the address phase edge.
  logic                       wr_pend_ff;
  logic [31:0]                wr_addr_ff;
  touch_scan_pkg::addr_dec_t  wr_dec;
  touch_scan_pkg::addr_dec_t  rd_dec;
  logic                       req_take;
  logic [7:0]                 rd_byte;
  // Global registers.
  logic [7:0]                 slot_timer_preset_ff;
  logic                       slot_overflow_flag_ff;
  logic                       detect_start_ff;
  logic                       sense_count_overflow_flag_ff;
  logic                       ref_count_overflow_flag_ff;
  logic                       shared_slot_select_ff;
  logic [1:0]                 count_clock_divider_ff;
  logic [15:0]                ref_count_ff;
  logic [15:0]                ref_live_ff;
  logic [2:0]                 prescale_ff;
  touch_scan_pkg::scan_state_t state_ff;
  logic                       wr_global;
  logic                       run;
  logic                       run_start;
  logic                       run_end;
  logic                       ref_tick;
  logic                       div4_tick;
  logic [NM-1:0]              done_now;
  logic [NM-1:0]              own_done;
  logic [NM-1:0]              sense_wrap;
  logic [7:0]                 mod_rd [NM];
  assign req_take  = hsel && htrans[1] && hready;
  assign rd_dec    = decode(haddr);
  assign wr_dec    = decode(wr_addr_ff);
  assign wr_global = wr_pend_ff && wr_dec.hit && !wr_dec.is_mod;
  assign run       = (state_ff == touch_scan_pkg::ST_RUN);
  assign run_start = (state_ff == touch_scan_pkg::ST_IDLE) && detect_start_ff;
  assign run_end   = run && (shared_slot_select_ff ? done_now[0] : &(own_done | done_now));
  assign div4_tick = (prescale_ff[1:0] == 2'h3);

  always_comb begin
    case (count_clock_divider_ff)
      2'h0:    ref_tick = 1'b1;
      2'h1:    ref_tick = prescale_ff[0];
      2'h2:    ref_tick = &prescale_ff[1:0];
      default: ref_tick = &prescale_ff;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 32'h0;
    end else begin
      wr_pend_ff <= req_take && hwrite;
      if (req_take) begin
        wr_addr_ff <= haddr;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (req_take && !hwrite) begin
        hrdata <= {24'h0, rd_byte};
      end
    end
  end

  always_comb begin
    rd_byte = 8'h0;
    if (rd_dec.hit && rd_dec.is_mod) begin
      rd_byte = mod_rd[rd_dec.mod];
    end else if (rd_dec.hit) begin
      case (rd_dec.ofs)
        `TS_OFS_SLOT_TIMER: rd_byte = slot_timer_preset_ff;
        `TS_OFS_SCAN_CTRL:  rd_byte = {1'b0, slot_overflow_flag_ff, detect_start_ff,
                                       sense_count_overflow_flag_ff, ref_count_overflow_flag_ff,
                                       shared_slot_select_ff, count_clock_divider_ff};
        `TS_OFS_FREQ_SEL:   rd_byte = {6'h0, sense_freq_select};
        `TS_OFS_REF_LO:     rd_byte = ref_count_ff[7:0];
        `TS_OFS_REF_HI:     rd_byte = ref_count_ff[15:8];
        default:            rd_byte = 8'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      slot_timer_preset_ff   <= 8'h0;
      detect_start_ff        <= 1'b0;
      shared_slot_select_ff  <= 1'b0;
      count_clock_divider_ff <= 2'h0;
      sense_freq_select      <= `TS_FREQ_SEL_RST;
    end else if (wr_global) begin
      case (wr_dec.ofs)
        `TS_OFS_SLOT_TIMER: slot_timer_preset_ff <= hwdata[7:0];
        `TS_OFS_SCAN_CTRL: begin
          detect_start_ff        <= hwdata[`TS_SC_START];
          shared_slot_select_ff  <= hwdata[`TS_SC_SHARED];
          count_clock_divider_ff <= hwdata[1:0];
        end
        `TS_OFS_FREQ_SEL:   sense_freq_select <= hwdata[1:0];
        default: ;
      endcase
    end
  end
  // Hardware setting wins over a software write that lands in the same cycle.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      slot_overflow_flag_ff        <= 1'b0;
      sense_count_overflow_flag_ff <= 1'b0;
      ref_count_overflow_flag_ff   <= 1'b0;
    end else begin
      if (run_end) begin
        slot_overflow_flag_ff <= 1'b1;
      end else if (wr_global && wr_dec.ofs == `TS_OFS_SCAN_CTRL) begin
        slot_overflow_flag_ff <= hwdata[`TS_SC_SLOT_OV];
      end
      if (|sense_wrap) begin
        sense_count_overflow_flag_ff <= 1'b1;
      end else if (wr_global && wr_dec.ofs == `TS_OFS_SCAN_CTRL) begin
        sense_count_overflow_flag_ff <= hwdata[`TS_SC_SENSE_OV];
      end
      if (run && ref_tick && &ref_live_ff) begin
        ref_count_overflow_flag_ff <= 1'b1;
      end else if (wr_global && wr_dec.ofs == `TS_OFS_SCAN_CTRL) begin
        ref_count_overflow_flag_ff <= hwdata[`TS_SC_REF_OV];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff <= touch_scan_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        touch_scan_pkg::ST_IDLE: begin
          if (run_start) begin
            state_ff <= touch_scan_pkg::ST_RUN;
          end
        end
        touch_scan_pkg::ST_RUN: begin
          if (!detect_start_ff) begin
            state_ff <= touch_scan_pkg::ST_IDLE;
          end else if (run_end) begin
            state_ff <= touch_scan_pkg::ST_DONE;
          end
        end
        touch_scan_pkg::ST_DONE: begin
          // A new run needs start to be written low and then high again.
          if (!detect_start_ff) begin
            state_ff <= touch_scan_pkg::ST_IDLE;
          end
        end
        default: state_ff <= touch_scan_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      touch_irq_request <= 1'b0;
    end else begin
      touch_irq_request <= run_end;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prescale_ff <= 3'h0;
    end else begin
      prescale_ff <= prescale_ff + 3'h1;
    end
  end
  // The live counter is cleared once the run ends, so the result is kept in a snapshot.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ref_live_ff  <= 16'h0;
      ref_count_ff <= 16'h0;
    end else if (!detect_start_ff || run_end) begin
      ref_live_ff <= 16'h0;
      if (run_end) begin
        ref_count_ff <= ref_live_ff;
      end
    end else if (run && ref_tick) begin
      ref_live_ff <= ref_live_ff + 16'h1;
    end
  end

  for (genvar m = 0; m < NM; m++) begin : g_mod
    logic [15:0] sense_cnt_ff;
    logic [15:0] count_ff;
    logic [4:0]  slot_cnt_ff;
    logic [7:0]  slot_timer_ff;
    logic        done_ff;
    logic [9:0]  cap_code_ff;
    logic [7:0]  key_hop_ff;
    logic [2:0]  hop_hw_ff;
    logic        slot_clk_sel_ff;
    logic        ref_en_ff;
    logic        key_en_ff;
    logic [2:0]  key_sync_ff;
    logic [2:0]  ref_sync_ff;
    logic        wr_mod;
    logic        key_edge;
    logic        slot_tick;
    logic        slot_active;
    logic        sense_active;
    assign wr_mod       = wr_pend_ff && wr_dec.hit && wr_dec.is_mod && wr_dec.mod == 3'(m);
    assign key_edge     = key_sync_ff[1] && !key_sync_ff[2] && key_en_ff;
    assign slot_tick    = slot_clk_sel_ff ? div4_tick
                                          : (ref_sync_ff[1] && !ref_sync_ff[2] && ref_en_ff);
    assign slot_active  = run && !done_ff && (!shared_slot_select_ff || m == 0);
    assign sense_active = run && (shared_slot_select_ff || !done_ff);
    assign done_now[m]  = slot_active && slot_tick && slot_timer_ff == `TS_TIMER_LAST
                          && slot_cnt_ff == `TS_SLOT_LAST;
    assign own_done[m]  = done_ff;
    assign sense_wrap[m] = sense_active && key_edge && &sense_cnt_ff;
    // Oscillator pins are free running; the first stage feeds only the second.
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        key_sync_ff <= 3'h0;
        ref_sync_ff <= 3'h0;
      end else begin
        key_sync_ff <= {key_sync_ff[1:0], key_osc_in[m][key_hop_ff[7:6]]};
        ref_sync_ff <= {ref_sync_ff[1:0], ref_osc_in[m]};
      end
    end

    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        cap_code_ff     <= 10'h0;
        key_hop_ff      <= 8'h0;
        slot_clk_sel_ff <= 1'b0;
        ref_en_ff       <= 1'b0;
        key_en_ff       <= 1'b0;
      end else if (wr_mod) begin
        case (wr_dec.ofs)
          `TS_OFS_CAP_LO:   cap_code_ff[7:0] <= hwdata[7:0];
          `TS_OFS_CAP_HI:   cap_code_ff[9:8] <= hwdata[1:0];
          `TS_OFS_KEY_HOP:  key_hop_ff <= hwdata[7:0];
          `TS_OFS_MOD_CTRL: begin
            slot_clk_sel_ff <= hwdata[`TS_MC_SLOT_CLK];
            ref_en_ff       <= hwdata[`TS_MC_REF_EN];
            key_en_ff       <= hwdata[`TS_MC_KEY_EN];
          end
          default: ;
        endcase
      end
    end
    // Slot timer counts up from the preset; each wrap advances the 5-bit counter.
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        sense_cnt_ff  <= 16'h0;
        slot_cnt_ff   <= 5'h0;
        slot_timer_ff <= 8'h0;
        done_ff       <= 1'b0;
        count_ff      <= 16'h0;
      end else if (run_end) begin
        count_ff      <= sense_cnt_ff;
        sense_cnt_ff  <= 16'h0;
        slot_cnt_ff   <= 5'h0;
        slot_timer_ff <= 8'h0;
        done_ff       <= 1'b0;
      end else if (!detect_start_ff) begin
        sense_cnt_ff <= 16'h0;
        slot_cnt_ff  <= 5'h0;
        done_ff      <= 1'b0;
      end else if (run_start) begin
        slot_timer_ff <= slot_timer_preset_ff;
        slot_cnt_ff   <= 5'h0;
        done_ff       <= 1'b0;
      end else begin
        if (sense_active && key_edge) begin
          sense_cnt_ff <= sense_cnt_ff + 16'h1;
        end
        if (done_now[m]) begin
          done_ff <= 1'b1;
        end else if (slot_active && slot_tick) begin
          if (slot_timer_ff == `TS_TIMER_LAST) begin
            slot_timer_ff <= slot_timer_preset_ff;
            slot_cnt_ff   <= slot_cnt_ff + 5'h1;
          end else begin
            slot_timer_ff <= slot_timer_ff + 8'h1;
          end
        end
      end
    end
    // Hardware hopping steps through all eight settings, one per run.
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        hop_hw_ff <= 3'h0;
      end else if (run_end && key_hop_ff[`TS_KH_HOP_SRC]) begin
        hop_hw_ff <= hop_hw_ff + 3'h1;
      end
    end

    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        osc_ctrl[m] <= '0;
      end else begin
        osc_ctrl[m].key_osc_run        <= key_en_ff && run && !done_ff;
        osc_ctrl[m].ref_osc_run        <= ref_en_ff && run && !done_ff;
        osc_ctrl[m].key_mux_select     <= key_hop_ff[`TS_KH_MUX_HI:`TS_KH_MUX_LO];
        osc_ctrl[m].ref_capacitor_code <= cap_code_ff;
        osc_ctrl[m].hop_freq           <= key_hop_ff[`TS_KH_HOP_SRC] ? hop_hw_ff
                                                                      : key_hop_ff[2:0];
        osc_ctrl[m].hop_control_source <= key_hop_ff[`TS_KH_HOP_SRC];
        osc_ctrl[m].multi_freq_enable  <= key_hop_ff[`TS_KH_MFEN];
        osc_ctrl[m].test_only_bit      <= key_hop_ff[`TS_KH_TEST];
      end
    end

    always_comb begin
      case (rd_dec.ofs)
        `TS_OFS_CNT_LO:   mod_rd[m] = count_ff[7:0];
        `TS_OFS_CNT_HI:   mod_rd[m] = count_ff[15:8];
        `TS_OFS_CAP_LO:   mod_rd[m] = cap_code_ff[7:0];
        `TS_OFS_CAP_HI:   mod_rd[m] = {6'h0, cap_code_ff[9:8]};
        `TS_OFS_KEY_HOP:  mod_rd[m] = key_hop_ff;
        `TS_OFS_MOD_CTRL: mod_rd[m] = {slot_clk_sel_ff, 1'b0, ref_en_ff, key_en_ff, 4'h0};
        default:          mod_rd[m] = 8'h0;
      endcase
    end
  end

endmodule

// ### pkg/touch_scan_defines.svh
`ifndef TOUCH_SCAN_DEFINES_SVH
`define TOUCH_SCAN_DEFINES_SVH

// Number of touch modules, four keys each.
`define TS_NUM_MOD        5
`define TS_KEYS_PER_MOD   4

// Global register byte offsets.
`define TS_OFS_SLOT_TIMER 5'h00
`define TS_OFS_SCAN_CTRL  5'h04
`define TS_OFS_FREQ_SEL   5'h08
`define TS_OFS_REF_LO     5'h0C
`define TS_OFS_REF_HI     5'h10

// Module register windows: base plus stride times module number.
`define TS_MOD_BASE       8'h40
`define TS_MOD_STRIDE     8'h20
`define TS_OFS_CNT_LO     5'h00
`define TS_OFS_CNT_HI     5'h04
`define TS_OFS_CAP_LO     5'h08
`define TS_OFS_CAP_HI     5'h0C
`define TS_OFS_KEY_HOP    5'h10
`define TS_OFS_MOD_CTRL   5'h14

// scan_control field positions.
`define TS_SC_SLOT_OV     6
`define TS_SC_START       5
`define TS_SC_SENSE_OV    4
`define TS_SC_REF_OV      3
`define TS_SC_SHARED      2

// module_key_hop_control and module control field positions.
`define TS_KH_MUX_HI      7
`define TS_KH_MUX_LO      6
`define TS_KH_MFEN        5
`define TS_KH_TEST        4
`define TS_KH_HOP_SRC     3
`define TS_MC_SLOT_CLK    7
`define TS_MC_REF_EN      5
`define TS_MC_KEY_EN      4

// Reset value and last slot and timer counts.
`define TS_FREQ_SEL_RST   2'h3
`define TS_SLOT_LAST      5'h1F
`define TS_TIMER_LAST     8'hFF

`endif

// ### pkg/touch_scan_pkg.sv
package touch_scan_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b11
  } scan_state_t;

  typedef struct packed {
    logic       hit;
    logic       is_mod;
    logic [2:0] mod;
    logic [4:0] ofs;
  } addr_dec_t;

  typedef struct packed {
    logic       key_osc_run;
    logic       ref_osc_run;
    logic [1:0] key_mux_select;
    logic [9:0] ref_capacitor_code;
    logic [2:0] hop_freq;
    logic       hop_control_source;
    logic       multi_freq_enable;
    logic       test_only_bit;
  } osc_ctrl_t;

endpackage

// ### testbench/capacitive_touch_scan_control_monitor.sv
`timescale 1ns/1ps
`include "touch_scan_defines.svh"
module capacitive_touch_scan_control_monitor (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        touch_irq_request,
  input wire logic [1:0]  sense_freq_select,
  input wire touch_scan_pkg::osc_ctrl_t [`TS_NUM_MOD-1:0] osc_ctrl
);
  logic       rd_tk;
  logic       wr_tk;
  logic       wr_freq;
  logic       wr_mux0;
  logic       wr_cap0;
  logic       rd_narrow;
  logic       any_run;
  logic [7:0] wd_byte;

  assign rd_tk     = hsel && htrans[1] && hready && !hwrite;
  assign wr_tk     = hsel && htrans[1] && hready && hwrite;
  assign wr_freq   = wr_tk && haddr == 32'(`TS_OFS_FREQ_SEL);
  assign wr_mux0   = wr_tk && haddr == 32'(`TS_MOD_BASE) + 32'(`TS_OFS_KEY_HOP);
  assign wr_cap0   = wr_tk && haddr == 32'(`TS_MOD_BASE) + 32'(`TS_OFS_CAP_LO);
  assign rd_narrow = rd_tk && (haddr == 32'(`TS_OFS_FREQ_SEL)
                     || haddr == 32'(`TS_MOD_BASE) + 32'(`TS_OFS_CAP_HI));
  assign wd_byte   = hwdata[7:0];

  always_comb begin
    any_run = 1'b0;
    for (int m = 0; m < `TS_NUM_MOD; m++) begin
      any_run = any_run | osc_ctrl[m].key_osc_run | osc_ctrl[m].ref_osc_run;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // A write lands one edge after its address phase, the oscillator controls one edge later.
  sequence s_freq_wr;
    wr_freq ##2 1'b1;
  endsequence
  sequence s_cap_wr;
    wr_cap0 ##3 1'b1;
  endsequence

  property p_irq_stop;
    touch_irq_request |=> !any_run;
  endproperty
  a_irq_stop: assert property (p_irq_stop)
    else $error("oscillators still run after end of run");
  property p_irq_once;
    touch_irq_request |=> !touch_irq_request [*8];
  endproperty
  a_irq_once: assert property (p_irq_once)
    else $error("end of run pulse repeated");
  property p_freq_value;
    s_freq_wr |-> {6'h00, sense_freq_select} == ($past(wd_byte) & 8'h03);
  endproperty
  a_freq_value: assert property (p_freq_value)
    else $error("frequency select differs from written value");
  property p_freq_hold;
    $changed(sense_freq_select) |-> $past(wr_freq, 2);
  endproperty
  a_freq_hold: assert property (p_freq_hold)
    else $error("frequency select changed without a write");
  property p_mux_hold;
    $changed(osc_ctrl[0].key_mux_select) |-> $past(wr_mux0, 3);
  endproperty
  a_mux_hold: assert property (p_mux_hold)
    else $error("key select changed without a write");
  property p_cap_value;
    s_cap_wr |-> osc_ctrl[0].ref_capacitor_code[7:0] == $past(wd_byte, 2);
  endproperty
  a_cap_value: assert property (p_cap_value)
    else $error("capacitor code differs from written value");
  property p_unimpl;
    rd_narrow |=> hrdata[31:2] == 30'h0;
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented bits read as one");
  property p_bus_ok;
    hreadyout && !hresp;
  endproperty
  a_bus_ok: assert property (p_bus_ok)
    else $error("bus response not ready and okay");
endmodule

// ### testbench/capacitive_touch_scan_control_bench.sv
`timescale 1ns/1ps
`include "touch_scan_defines.svh"
module capacitive_touch_scan_control_bench;
  localparam logic [31:0] adr_tmr  = 32'(`TS_OFS_SLOT_TIMER);
  localparam logic [31:0] adr_scan = 32'(`TS_OFS_SCAN_CTRL);
  localparam logic [31:0] adr_freq = 32'(`TS_OFS_FREQ_SEL);
  localparam logic [31:0] adr_ref  = 32'(`TS_OFS_REF_LO);
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [`TS_NUM_MOD-1:0][`TS_KEYS_PER_MOD-1:0] key_osc_in = '0;
  logic [`TS_NUM_MOD-1:0] ref_osc_in = '0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        touch_irq_request;
  logic [1:0]  sense_freq_select;
  touch_scan_pkg::osc_ctrl_t [`TS_NUM_MOD-1:0] osc_ctrl;
  int          n_errors = 0;
  int          checks_done = 0;
  int          tick = 0;
  int          cyc;
  logic [31:0] v;

  capacitive_touch_scan_control dut (
    .core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .key_osc_in, .ref_osc_in,
    .hrdata, .hreadyout, .hresp, .touch_irq_request, .sense_freq_select, .osc_ctrl
  );

  always #50 core_clk = ~core_clk;

  // Oscillators only swing while the block runs them; key k has period 2k+4, reference 8.
  always @(posedge core_clk) begin
    tick <= tick + 1;
    for (int m = 0; m < `TS_NUM_MOD; m++) begin
      ref_osc_in[m] <= osc_ctrl[m].ref_osc_run && (tick % 8) < 4;
      for (int k = 0; k < 4; k++) begin
        key_osc_in[m][k] <= osc_ctrl[m].key_osc_run && (tick % (2 * k + 4)) < (k + 2);
      end
    end
  end

  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic ready_edge;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      test_done;
    end
  endtask

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [7:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    ready_edge;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    ready_edge;
    v = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 8'h00);
    check(what, v, exp);
  endtask

  task automatic rd16(input logic [31:0] a);
    logic [7:0] lo;
    xfer(1'b0, a, 8'h00);
    lo = v[7:0];
    xfer(1'b0, a + 32'h4, 8'h00);
    v = {16'h0, v[7:0], lo};
  endtask

  function automatic logic [31:0] ma(input int m, input logic [4:0] ofs);
    return 32'(`TS_MOD_BASE) + 32'(`TS_MOD_STRIDE) * 32'(m) + 32'(ofs);
  endfunction

  // An unknown reading makes the comparison unknown, so it cannot pass.
  function automatic logic [31:0] near(input logic [31:0] seen, input int exp, input int tol);
    return (seen + 32'(tol) >= 32'(exp) && seen <= 32'(exp + tol)) ? 32'h1 : 32'h0;
  endfunction

  // A new run needs the start bit low first; counts cycles up to the end-of-run pulse.
  task automatic run(input logic [7:0] ctrl);
    wr(adr_scan, ctrl);
    wr(adr_scan, ctrl | 8'h20);
    cyc = 0;
    while (touch_irq_request !== 1'b1 && cyc < 3000) begin
      @(posedge core_clk);
      cyc++;
    end
    if (cyc >= 3000) begin
      n_errors++;
      test_done;
    end
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    check("freq port", {30'h0, sense_freq_select}, 32'h3);
    rd_chk("preset", adr_tmr, 32'h0);
    rd_chk("scan control", adr_scan, 32'h0);
    rd_chk("freq select", adr_freq, 32'h3);
    rd_chk("ref low", adr_ref, 32'h0);
    rd_chk("ref high", adr_ref + 32'h4, 32'h0);
    rd_chk("unmapped", 32'h3C, 32'h0);
    for (int m = 0; m < `TS_NUM_MOD; m++) begin
      for (int o = 0; o < 6; o++) begin
        rd_chk("module reg", ma(m, 5'(4 * o)), 32'h0);
      end
    end
    for (int f = 0; f < 4; f++) begin
      wr(adr_freq, 8'hFC | 8'(f));
      @(posedge core_clk);
      check("freq port", {30'h0, sense_freq_select}, 32'(f));
      rd_chk("freq readback", adr_freq, 32'(f));
    end
    wr(ma(0, `TS_OFS_CAP_LO), 8'hA5);
    wr(ma(0, `TS_OFS_CAP_HI), 8'hFE);
    rd_chk("cap high", ma(0, `TS_OFS_CAP_HI), 32'h2);
    // Key select 3, multi-frequency on, test bit kept low, hop taken from the field.
    for (int h = 0; h < 8; h++) begin
      wr(ma(0, `TS_OFS_KEY_HOP), 8'hE0 | 8'(h));
      repeat (2) @(posedge core_clk);
      check("hop field", 32'(osc_ctrl[0].hop_freq), 32'(h));
    end
    check("cap code", 32'(osc_ctrl[0].ref_capacitor_code), 32'h2A5);
    check("key select", 32'(osc_ctrl[0].key_mux_select), 32'h3);
    check("multi freq", 32'(osc_ctrl[0].multi_freq_enable), 32'h1);
    check("test bit", 32'(osc_ctrl[0].test_only_bit), 32'h0);
    wr(adr_scan, 8'h98);
    rd_chk("sticky set", adr_scan, 32'h18);
    wr(adr_scan, 8'h00);
    rd_chk("sticky clear", adr_scan, 32'h0);
    for (int m = 0; m < `TS_NUM_MOD; m++) begin
      wr(ma(m, `TS_OFS_MOD_CTRL), 8'hB0);
    end
    // Module 0 ticks every fourth cycle: (256 - 252) * 32 ticks make 512 cycles.
    wr(adr_tmr, 8'hFC);
    for (int d = 0; d < 4; d++) begin
      run(8'h04 | 8'(d));
      check("run time", near(32'(cyc), 512, 8), 32'h1);
      rd_chk("flags", adr_scan, 32'h64 | 32'(d));
      rd16(adr_ref);
      check("ref count", near(v, 512 >> d, 6), 32'h1);
      rd16(ma(0, `TS_OFS_CNT_LO));
      check("key 4 count", near(v, 51, 3), 32'h1);
      rd16(ma(1, `TS_OFS_CNT_LO));
      check("key 1 count", near(v, 128, 3), 32'h1);
    end
    for (int m = 1; m < `TS_NUM_MOD; m++) begin
      wr(ma(m, `TS_OFS_MOD_CTRL), 8'h30);
    end
    // Hardware hopping: the field value 5 must be ignored, the step counter starts at 0.
    wr(ma(0, `TS_OFS_KEY_HOP), 8'hED);
    repeat (2) @(posedge core_clk);
    check("hop ignores field", 32'(osc_ctrl[0].hop_freq), 32'h0);
    check("hop source", 32'(osc_ctrl[0].hop_control_source), 32'h1);
    run(8'h04);
    check("shared time", near(32'(cyc), 512, 8), 32'h1);
    run(8'h00);
    check("own time", near(32'(cyc), 1024, 24), 32'h1);
    rd16(adr_ref);
    check("own ref count", near(v, 1024, 24), 32'h1);
    check("hop steps", 32'(osc_ctrl[0].hop_freq), 32'h2);
    wr(ma(2, `TS_OFS_MOD_CTRL), 8'h80);
    wr(adr_tmr, 8'h00);
    wr(adr_scan, 8'h04);
    wr(adr_scan, 8'h24);
    repeat (50) @(posedge core_clk);
    check("key osc on", 32'(osc_ctrl[0].key_osc_run), 32'h1);
    check("ref osc on", 32'(osc_ctrl[0].ref_osc_run), 32'h1);
    check("osc disabled", 32'(osc_ctrl[2].key_osc_run), 32'h0);
    wr(adr_scan, 8'h04);
    cyc = 0;
    repeat (300) begin
      @(posedge core_clk);
      cyc += (touch_irq_request === 1'b1) ? 1 : 0;
    end
    check("abort pulses", 32'(cyc), 32'h0);
    check("osc stopped", 32'(osc_ctrl[0].key_osc_run), 32'h0);
    test_done;
  end
endmodule

bind capacitive_touch_scan_control capacitive_touch_scan_control_monitor u_mon (
  .core_clk          (core_clk),
  .rst_n             (rst_n),
  .hsel              (hsel),
  .haddr             (haddr),
  .htrans            (htrans),
  .hwrite            (hwrite),
  .hwdata            (hwdata),
  .hready            (hready),
  .hrdata            (hrdata),
  .hreadyout         (hreadyout),
  .hresp             (hresp),
  .touch_irq_request (touch_irq_request),
  .sense_freq_select (sense_freq_select),
  .osc_ctrl          (osc_ctrl)
);
